// *** dv/dcfg_regs_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcfg_regs_tb_top;
	// **********************************************
	// stimulus and observed signals
	// **********************************************
	localparam logic [15:0] KEY = 16'hA5C3; // arbitrary unlock value
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        line_done = 1'b0;
	logic        frame_start = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        dot_en;
	logic        pixel_en;
	logic        video_on;
	logic        video_fast;
	logic        split_hit;
	logic [19:0] fetch_addr;
	int          n_errors = 0;
	int          num_checks = 0;

	dcfg_regs #(.UNLOCK_VALUE(KEY)) i_dut
	(
		.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_LINE_DONE(line_done),
		.I_FRAME_START(frame_start), .O_DOT_EN(dot_en), .O_PIXEL_EN(pixel_en),
		.O_VIDEO_ON(video_on), .O_VIDEO_FAST(video_fast), .O_SPLIT_HIT(split_hit),
		.O_FETCH_ADDR(fetch_addr)
	);

	// 50 MHz clock
	always #10 clk = ~clk;

	// **********************************************
	// shared helpers
	// **********************************************
	task automatic summarize;
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer; the master holds everything until pready is seen high
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle count is assumed here; only the watchdog ends a hung wait
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		chk("pready", 32'h0000_0001, {31'h0000_0000, pready});
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(nm, exp, r);
		chk("pslverr", 32'h0000_0000, {31'h0000_0000, e});
	endtask

	// one-cycle pulse on the frame start input
	task automatic new_frame;
		@(posedge clk);
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
	endtask

	// **********************************************
	// scenarios
	// **********************************************
	task automatic t_reset;
		rdc("key", dcfg_pkg::OFS_KEY, 32'h0000_0000);
		rdc("settings", dcfg_pkg::OFS_MAIN, 32'h0000_0000);
		rdc("split line", dcfg_pkg::OFS_SPLIT, 32'h0000_0000);
		chk("video on", 32'h0000_0000, {31'h0000_0000, video_on});
		chk("video fast", 32'h0000_0000, {31'h0000_0000, video_fast});
	endtask

	// locked write dropped, then key, all six settings bits and the video outputs
	task automatic t_lock;
		wr(dcfg_pkg::OFS_MAIN, 32'h3000_0000);
		rdc("locked settings", dcfg_pkg::OFS_MAIN, 32'h0000_0000);
		wr(dcfg_pkg::OFS_KEY, {16'h0000, KEY});
		rdc("key", dcfg_pkg::OFS_KEY, {16'h0000, KEY});
		wr(dcfg_pkg::OFS_MAIN, 32'hFC00_0000);
		rdc("settings", dcfg_pkg::OFS_MAIN, 32'hFC00_0000);
		// software keeps the handshake speed bit at one in every write
		wr(dcfg_pkg::OFS_MAIN, 32'h3000_0000);
		repeat (3) @(posedge clk);
		chk("video on", 32'h0000_0001, {31'h0000_0000, video_on});
		chk("video fast", 32'h0000_0001, {31'h0000_0000, video_fast});
		wr(dcfg_pkg::OFS_MAIN, 32'h2000_0000);
		repeat (3) @(posedge clk);
		chk("video on", 32'h0000_0000, {31'h0000_0000, video_on});
		chk("video fast", 32'h0000_0001, {31'h0000_0000, video_fast});
	endtask

	// all four halving combinations, counted over 16 cycles
	task automatic t_clk;
		int nd;
		int np;
		for (int i = 0; i < 4; i++)
		begin
			wr(dcfg_pkg::OFS_MAIN, {i[1], i[0], 1'b1, 29'h0000_0000});
			repeat (4) @(posedge clk);
			nd = 0;
			np = 0;
			repeat (16)
			begin
				@(posedge clk);
				nd += (dot_en === 1'b1);
				np += (pixel_en === 1'b1);
			end
			chk("dot enables", i[1] ? 8 : 16, nd);
			chk("pixel enables", (i[1] ? 8 : 16) >> i[0], np);
		end
	endtask

	// halving off: fetch steps every cycle, by one or by four
	task automatic t_fetch;
		logic [19:0] a0;
		for (int f = 0; f < 2; f++)
		begin
			wr(dcfg_pkg::OFS_MAIN, {6'b001000 | {5'b00000, f[0]}, 26'h000_0000});
			new_frame();
			repeat (4) @(posedge clk);
			a0 = fetch_addr;
			repeat (10) @(posedge clk);
			chk("fetch step", f ? 40 : 10, {12'h000, fetch_addr - a0});
		end
	endtask

	// split line 3: match only on the fourth line and only when enabled
	task automatic t_split;
		wr(dcfg_pkg::OFS_SPLIT, 32'h0000_0003);
		rdc("split line", dcfg_pkg::OFS_SPLIT, 32'h0000_0003);
		for (int en = 0; en < 2; en++)
		begin
			wr(dcfg_pkg::OFS_MAIN, {4'b0010, en[0], 27'h000_0000});
			new_frame();
			for (int k = 0; k < 4; k++)
			begin
				@(posedge clk);
				line_done <= 1'b1;
				@(posedge clk);
				line_done <= 1'b0;
				@(posedge clk);
				chk("split hit", (en == 1 && k == 3), {31'h0000_0000, split_hit});
				if (en == 1 && k == 3)
					chk("fetch after split", 32'h0000_0000, {12'h000, fetch_addr});
			end
		end
		// four finished lines since the last frame start
		rdc("line count", dcfg_pkg::OFS_LINE, 32'h0000_0004);
	endtask

	// index selects the entry; reserved upper bits are written as zero
	task automatic t_pal;
		wr(dcfg_pkg::OFS_PIDX, 32'h0000_0005);
		wr(dcfg_pkg::OFS_PVAL, 32'h0011_2233);
		wr(dcfg_pkg::OFS_PIDX, 32'h0000_0006);
		wr(dcfg_pkg::OFS_PVAL, 32'h0044_5566);
		wr(dcfg_pkg::OFS_PIDX, 32'h0000_0005);
		rdc("colour index", dcfg_pkg::OFS_PIDX, 32'h0000_0005);
		rdc("colour value", dcfg_pkg::OFS_PVAL, 32'h0011_2233);
	endtask

	// a full lap of writes brings the pointer back, so reads replay them
	task automatic t_queue;
		logic [15:0] a;
		for (int q = 0; q < 2; q++)
		begin
			a = q ? dcfg_pkg::OFS_CQ : dcfg_pkg::OFS_DQ;
			for (int i = 0; i < 64; i++)
				wr(a, 32'hC0DE_0000 ^ (i * 32'h0001_0101) ^ q);
			for (int i = 0; i < 64; i++)
				rdc("queue word", a, 32'hC0DE_0000 ^ (i * 32'h0001_0101) ^ q);
		end
	endtask

	// unmapped and misaligned accesses are flagged and have no effect
	task automatic t_bad;
		logic [31:0] r;
		logic        e;
		apb(1'b0, 16'h8360, 32'h0000_0000, r, e);
		chk("unmapped data", 32'h0000_0000, r);
		chk("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
		apb(1'b1, 16'h8306, 32'hFC00_0000, r, e);
		chk("misaligned error", 32'h0000_0001, {31'h0000_0000, e});
		rdc("settings", dcfg_pkg::OFS_MAIN, {4'b0010, 1'b1, 27'h000_0000});
	endtask

	// **********************************************
	// main sequence and watchdog
	// **********************************************
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_lock();
		t_clk();
		t_fetch();
		t_split();
		t_pal();
		t_queue();
		t_bad();
		summarize();
	end

	// the queue lap dominates the run; 20000 cycles leaves ample margin
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire

// *** rtl/dcfg_clkdiv.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcfg_clkdiv
(
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_dot_halve,
	input  wire logic i_pixel_halve,
	output logic      o_dot_en,
	output logic      o_pixel_en
);
	logic dot_phase;
	logic pix_phase;
	logic next_dot_en;
	logic next_pixel_en;

	// **********************************************
	// enable dividers
	// **********************************************
	// dot enable is every cycle, or every other cycle when halved
	assign next_dot_en   = ~i_dot_halve | dot_phase;
	// pixel enable is derived from the dot enable so the two never drift
	assign next_pixel_en = next_dot_en & (~i_pixel_halve | pix_phase);

	// free running phase of the dot divider
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			dot_phase <= 1'b0;
		else
			dot_phase <= ~dot_phase;
	end

	// pixel phase only moves on dot ticks
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			pix_phase <= 1'b0;
		else if (next_dot_en)
			pix_phase <= ~pix_phase;
	end

	// registered enables, so consumers see clean one-cycle pulses
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_dot_en   <= 1'b0;
			o_pixel_en <= 1'b0;
		end
		else
		begin
			o_dot_en   <= next_dot_en;
			o_pixel_en <= next_pixel_en;
		end
	end
endmodule
`default_nettype wire

// *** rtl/dcfg_pkg.sv ***
`default_nettype none
package dcfg_pkg;
	// **********************************************
	// register offsets
	// **********************************************
	localparam logic [15:0] OFS_KEY   = 16'h8300;
	localparam logic [15:0] OFS_MAIN  = 16'h8304;
	localparam logic [15:0] OFS_FETCH = 16'h8308;
	localparam logic [15:0] OFS_LINE  = 16'h830C;
	localparam logic [15:0] OFS_SPLIT = 16'h835C;
	localparam logic [15:0] OFS_PIDX  = 16'h8370;
	localparam logic [15:0] OFS_PVAL  = 16'h8374;
	localparam logic [15:0] OFS_DQ    = 16'h8378;
	localparam logic [15:0] OFS_CQ    = 16'h837C;
	// **********************************************
	// field layout and reset values
	// **********************************************
	localparam int BIT_DOT   = 31;
	localparam int BIT_PIX   = 30;
	localparam int BIT_FAST  = 29;
	localparam int BIT_VIDEO = 28;
	localparam int BIT_SPLIT = 27;
	localparam int BIT_FOUR  = 26;
	localparam int KEY_W     = 16;
	localparam logic [15:0] RST_KEY  = 16'h0000;
	localparam logic [31:0] RST_MAIN = 32'h0000_0000;
	localparam logic [2:0]  STEP_ONE  = 3'h1;
	localparam logic [2:0]  STEP_FOUR = 3'h4;
	localparam int NUM_QUEUES = 2;
	// upper settings bits, in bit order 31 down to 26
	typedef struct packed {
		logic dot_clock_halve;
		logic pixel_clock_halve;
		logic video_handshake_speed;
		logic motion_video_on;
		logic split_screen_compare_on;
		logic every_fourth_dword_fetch;
	} dcfg_settings_s;
	localparam dcfg_settings_s RST_SETTINGS = dcfg_settings_s'(RST_MAIN[31:26]);
endpackage
`default_nettype wire

// *** rtl/dcfg_regs.sv ***
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module dcfg_regs
#(
	parameter logic [15:0] UNLOCK_VALUE = 16'hA5C3, // arbitrary value
	parameter int          PAL_AW       = 8,
	parameter int          PAL_W        = 24,
	parameter int          DIAG_AW      = 6,
	parameter int          LINE_W       = 11,
	parameter int          FETCH_W      = 20
)
(
	input  wire logic                I_CLK,
	input  wire logic                I_RESET,
	input  wire logic                I_PSEL,
	input  wire logic                I_PENABLE,
	input  wire logic                I_PWRITE,
	input  wire logic [15:0]         I_PADDR,
	input  wire logic [31:0]         I_PWDATA,
	output logic      [31:0]         O_PRDATA,
	output logic                     O_PREADY,
	output logic                     O_PSLVERR,
	input  wire logic                I_LINE_DONE,
	input  wire logic                I_FRAME_START,
	output logic                     O_DOT_EN,
	output logic                     O_PIXEL_EN,
	output logic                     O_VIDEO_ON,
	output logic                     O_VIDEO_FAST,
	output logic                     O_SPLIT_HIT,
	output logic      [FETCH_W-1:0]  O_FETCH_ADDR
);
	// **********************************************
	// elaboration checks
	// **********************************************
	if (PAL_AW < 1 || PAL_AW > 8)
	begin : g_bad_pal
		$error("palette address width out of range");
	end
	if (PAL_W < 1 || PAL_W > 32 || DIAG_AW < 1 || DIAG_AW > 10)
	begin : g_bad_mem
		$error("memory geometry out of range");
	end
	if (LINE_W < 1 || LINE_W > 32 || FETCH_W < 3 || FETCH_W > 32)
	begin : g_bad_cnt
		$error("counter width out of range");
	end

	// **********************************************
	// state
	// **********************************************
	logic [15:0]             key;
	dcfg_pkg::dcfg_settings_s settings;
	logic [LINE_W-1:0]       split_line;
	logic [LINE_W-1:0]       line_cnt;
	logic [PAL_AW-1:0]       pal_idx;
	logic [PAL_W-1:0]        pal_mem [1<<PAL_AW];
	logic [31:0]             q_rdata [dcfg_pkg::NUM_QUEUES];
	logic [DIAG_AW-1:0]      q_ptr   [dcfg_pkg::NUM_QUEUES];
	logic [31:0]             next_rdata;
	logic                    next_err;
	logic                    setup;
	logic                    access;
	logic                    wr;
	logic                    unlocked;
	logic                    split_match;
	logic [2:0]              step;

	// **********************************************
	// apb handshake
	// **********************************************
	// read data and error are prepared in the setup cycle, so the
	// access phase always ends at its first edge with no wait state
	assign setup    = I_PSEL & ~I_PENABLE;
	assign access   = I_PSEL & I_PENABLE & O_PREADY;
	assign wr       = access & I_PWRITE;
	assign unlocked = (key == UNLOCK_VALUE);

	// ready is high only in the first access cycle
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			O_PREADY <= 1'b0;
		else
			O_PREADY <= setup;
	end

	// read mux; unmapped or misaligned addresses answer with an error
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		unique case (I_PADDR)
			dcfg_pkg::OFS_KEY:   next_rdata[15:0] = key;
			dcfg_pkg::OFS_MAIN:  next_rdata[31:26] = settings;
			dcfg_pkg::OFS_FETCH: next_rdata[FETCH_W-1:0] = O_FETCH_ADDR;
			dcfg_pkg::OFS_LINE:  next_rdata[LINE_W-1:0] = line_cnt;
			dcfg_pkg::OFS_SPLIT: next_rdata[LINE_W-1:0] = split_line;
			dcfg_pkg::OFS_PIDX:  next_rdata[PAL_AW-1:0] = pal_idx;
			dcfg_pkg::OFS_PVAL:  next_rdata[PAL_W-1:0] = pal_mem[pal_idx];
			dcfg_pkg::OFS_DQ:    next_rdata = q_rdata[0];
			dcfg_pkg::OFS_CQ:    next_rdata = q_rdata[1];
			default:             next_err = 1'b1;
		endcase
	end

	// read data and slave error register at the setup edge
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			O_PRDATA  <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end
		else if (setup)
		begin
			O_PRDATA  <= I_PWRITE ? 32'h0000_0000 : next_rdata;
			O_PSLVERR <= next_err;
		end
		else
		begin
			O_PRDATA  <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end
	end

	// **********************************************
	// configuration registers
	// **********************************************
	// the key itself is never locked, otherwise nothing could unlock
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			key <= dcfg_pkg::RST_KEY;
		else if (wr && I_PADDR == dcfg_pkg::OFS_KEY)
			key <= I_PWDATA[dcfg_pkg::KEY_W-1:0];
	end

	// locked settings; writes with the wrong key are dropped silently
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			settings <= dcfg_pkg::RST_SETTINGS;
		else if (wr && unlocked && I_PADDR == dcfg_pkg::OFS_MAIN)
			settings <= dcfg_pkg::dcfg_settings_s'(I_PWDATA[31:26]);
	end

	// split line number, locked like the settings
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			split_line <= '0;
		else if (wr && unlocked && I_PADDR == dcfg_pkg::OFS_SPLIT)
			split_line <= I_PWDATA[LINE_W-1:0];
	end

	// video port controls are copied to flops that leave the block
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
		begin
			O_VIDEO_ON   <= 1'b0;
			O_VIDEO_FAST <= 1'b0;
		end
		else
		begin
			O_VIDEO_ON   <= settings.motion_video_on;
			O_VIDEO_FAST <= settings.video_handshake_speed;
		end
	end

	// **********************************************
	// colour table
	// **********************************************
	// index does not advance; software rewrites it before each access
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			pal_idx <= '0;
		else if (wr && I_PADDR == dcfg_pkg::OFS_PIDX)
			pal_idx <= I_PWDATA[PAL_AW-1:0];
	end

	// table contents have no reset, like any ram
	always_ff @(posedge I_CLK)
	begin
		if (wr && I_PADDR == dcfg_pkg::OFS_PVAL)
			pal_mem[pal_idx] <= I_PWDATA[PAL_W-1:0];
	end

	// **********************************************
	// diagnostic queue rams
	// **********************************************
	// queue 0 is the pixel queue, queue 1 the packed line queue; each
	// access of either direction steps that queue's pointer by one
	for (genvar g = 0; g < dcfg_pkg::NUM_QUEUES; g++)
	begin : g_queue
		logic [31:0]  mem [1<<DIAG_AW];
		logic         hit;
		assign hit = access &&
			I_PADDR == (g == 0 ? dcfg_pkg::OFS_DQ : dcfg_pkg::OFS_CQ);
		assign q_rdata[g] = mem[q_ptr[g]];

		// test write into the ram
		always_ff @(posedge I_CLK)
		begin
			if (hit && I_PWRITE)
				mem[q_ptr[g]] <= I_PWDATA;
		end

		// pointer walks the ram so a burst of reads dumps it in order
		always_ff @(posedge I_CLK)
		begin
			if (I_RESET)
				q_ptr[g] <= '0;
			else if (hit)
				q_ptr[g] <= q_ptr[g] + 1'b1;
		end
	end

	// **********************************************
	// clock enables and scan
	// **********************************************
	dcfg_clkdiv u_div
	(
		.i_clk         (I_CLK),
		.i_reset       (I_RESET),
		.i_dot_halve   (settings.dot_clock_halve),
		.i_pixel_halve (settings.pixel_clock_halve),
		.o_dot_en      (O_DOT_EN),
		.o_pixel_en    (O_PIXEL_EN)
	);

	// line counter restarts at each frame
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET || I_FRAME_START)
			line_cnt <= '0;
		else if (I_LINE_DONE)
			line_cnt <= line_cnt + 1'b1;
	end

	// compare runs at the end of every line against the finished line
	assign split_match = I_LINE_DONE && settings.split_screen_compare_on
		&& line_cnt == split_line;
	// chain-4 skip steps four dwords per fetch instead of one
	assign step = settings.every_fourth_dword_fetch ?
		dcfg_pkg::STEP_FOUR : dcfg_pkg::STEP_ONE;

	// fetch address: frame start and split match win over stepping
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET || I_FRAME_START)
			O_FETCH_ADDR <= '0;
		else if (split_match)
			O_FETCH_ADDR <= '0;
		else if (O_PIXEL_EN)
			O_FETCH_ADDR <= O_FETCH_ADDR + FETCH_W'(step);
	end

	// one-cycle marker of a split match
	always_ff @(posedge I_CLK)
	begin
		if (I_RESET)
			O_SPLIT_HIT <= 1'b0;
		else
			O_SPLIT_HIT <= split_match && !I_FRAME_START;
	end

	// **********************************************
	// assertions
	// **********************************************
	sequence s_main_write;
		wr && I_PADDR == dcfg_pkg::OFS_MAIN;
	endsequence

	sequence s_setup_read(logic [15:0] ofs);
		setup && !I_PWRITE && I_PADDR == ofs;
	endsequence

	property p_ready_after_setup;
		@(posedge I_CLK) disable iff (I_RESET)
		setup |=> O_PREADY ##1 !O_PREADY;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("ready not one cycle after setup");

	property p_locked_write;
		@(posedge I_CLK) disable iff (I_RESET)
		s_main_write and !unlocked |=> $stable(settings);
	endproperty
	a_locked_write: assert property (p_locked_write)
		else $error("settings changed while locked");

	property p_video_follow;
		@(posedge I_CLK) disable iff (I_RESET)
		s_main_write and unlocked |=> ##1
			O_VIDEO_ON == $past(I_PWDATA[dcfg_pkg::BIT_VIDEO], 2) &&
			O_VIDEO_FAST == $past(I_PWDATA[dcfg_pkg::BIT_FAST], 2);
	endproperty
	a_video_follow: assert property (p_video_follow)
		else $error("video port bits do not follow write");

	property p_key_reserved;
		@(posedge I_CLK) disable iff (I_RESET)
		s_setup_read(dcfg_pkg::OFS_KEY) |=> O_PRDATA[31:16] == 16'h0000;
	endproperty
	a_key_reserved: assert property (p_key_reserved)
		else $error("reserved key bits not zero");

	property p_split_reset;
		@(posedge I_CLK) disable iff (I_RESET)
		split_match && !I_FRAME_START |=> O_FETCH_ADDR == '0 && O_SPLIT_HIT;
	endproperty
	a_split_reset: assert property (p_split_reset)
		else $error("fetch not reset on split match");

	property p_fetch_step;
		@(posedge I_CLK) disable iff (I_RESET)
		O_PIXEL_EN && !split_match && !I_FRAME_START |=>
			O_FETCH_ADDR == $past(O_FETCH_ADDR) + FETCH_W'($past(step));
	endproperty
	a_fetch_step: assert property (p_fetch_step)
		else $error("fetch step wrong");

	property p_dot_half;
		@(posedge I_CLK) disable iff (I_RESET)
		O_DOT_EN && settings.dot_clock_halve && $past(settings.dot_clock_halve)
			|=> !O_DOT_EN;
	endproperty
	a_dot_half: assert property (p_dot_half)
		else $error("dot enable not halved");

	property p_pixel_half;
		@(posedge I_CLK) disable iff (I_RESET)
		O_PIXEL_EN && settings.pixel_clock_halve && !settings.dot_clock_halve &&
			$past(settings.pixel_clock_halve) && !$past(settings.dot_clock_halve)
			|=> !O_PIXEL_EN;
	endproperty
	a_pixel_half: assert property (p_pixel_half)
		else $error("pixel enable not halved");

	property p_index_write;
		@(posedge I_CLK) disable iff (I_RESET)
		wr && I_PADDR == dcfg_pkg::OFS_PIDX |=>
			pal_idx == $past(I_PWDATA[PAL_AW-1:0]);
	endproperty
	a_index_write: assert property (p_index_write)
		else $error("colour index not stored");

	property p_queue_step;
		@(posedge I_CLK) disable iff (I_RESET)
		access && I_PADDR == dcfg_pkg::OFS_DQ |=> q_ptr[0] == $past(q_ptr[0]) + 1'b1;
	endproperty
	a_queue_step: assert property (p_queue_step)
		else $error("pixel queue pointer did not step");
endmodule
`default_nettype wire
